/* qsm_consts.svh */
`ifndef QSM_CONSTS_SVH
`define QSM_CONSTS_SVH
`define QSM_OP_DPD 8'hB9
`define QSM_OP_WAKE 8'hAB
`define QSM_OP_XIP 8'h6B
`define QSM_ADDR_BITS 32
`define QSM_WIN_BITS 27
`define QSM_DATA_BITS 64
`define QSM_MAX_BYTES 4'h8
`define QSM_WORD_BYTES 4'h4
`define QSM_XIP_BYTES 4'h4
`define QSM_OP_CNT 7'h08
`define QSM_ADDR_CNT 7'h20
`define QSM_SCK_MAX_KHZ 32000
`define QSM_SCK_MIN_KHZ 2000
`endif

/* qsm_pkg.sv */
`include "qsm_consts.svh"
package qsm_pkg;
    typedef enum logic [1:0] {LANE_ONE = 2'h0, LANE_TWO = 2'h1, LANE_FOUR = 2'h2} lane_mode_e;
    typedef enum logic [1:0] {K_CMD = 2'h0, K_XIP = 2'h1, K_PWR = 2'h2} op_kind_e;
    typedef enum logic [2:0] {
        CS_IDLE = 3'h0, CS_FETCH = 3'h1, CS_RUN = 3'h3, CS_STORE = 3'h2, CS_DONE = 3'h6
    } ctl_state_e;
    typedef enum logic [2:0] {
        L_IDLE = 3'h0, L_SEL = 3'h1, L_OP = 3'h3, L_ADDR = 3'h2,
        L_WR = 3'h6, L_RD = 3'h7, L_HOLD = 3'h5, L_END = 3'h4
    } link_state_e;
    typedef struct packed {
        logic [7:0] opcode;
        logic addr_en;
        logic [`QSM_ADDR_BITS-1:0] addr;
        lane_mode_e mode;
        logic [3:0] wbytes;
        logic [3:0] rbytes;
        logic [`QSM_DATA_BITS-1:0] wdata;
        logic [7:0] half;
    } xfer_s;

    function automatic logic [2:0] lane_count(input lane_mode_e m);
        unique case (m)
            LANE_ONE: lane_count = 3'h1;
            LANE_TWO: lane_count = 3'h2;
            LANE_FOUR: lane_count = 3'h4;
            default: lane_count = 3'h1;
        endcase
    endfunction
endpackage

/* qsm_xfer_if.sv */
`timescale 1ns/1ps
interface qsm_xfer_if;
    logic start;
    qsm_pkg::xfer_s req;
    logic done;
    logic [`QSM_DATA_BITS-1:0] resp;
    modport cdc (output start, output req, input done, input resp);
    modport link (input start, input req, output done, output resp);
endinterface

/* qsm_pin_sync.sv */
`timescale 1ns/1ps
module qsm_pin_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [2:0] sh;
        logic q;
        logic next_q;
        // Second and third stages agree
        always_comb begin
            next_q = (sh[1] == sh[2]) ? sh[2] : q;
        end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                sh <= 3'h0;
                q <= 1'b0;
            end else begin
                sh <= {sh[1:0], d_i[i]};
                q <= next_q;
            end
        end
        assign q_o[i] = q;
    end
endmodule // qsm_pin_sync

/* qsm_hs_cdc.sv */
`timescale 1ns/1ps
module qsm_hs_cdc (
    // System side
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input qsm_pkg::xfer_s req_i,
    output logic done_o,
    output logic [`QSM_DATA_BITS-1:0] rsp_o,
    // Link side
    input wire logic clk_link_i,
    input wire logic link_rst_i,
    qsm_xfer_if.cdc bus
);
    logic req_tog, next_req_tog, ack_seen, ack_q;
    qsm_pkg::xfer_s req_hold, next_req_hold;
    logic ack_tog, next_ack_tog, req_seen, req_q;
    logic [`QSM_DATA_BITS-1:0] rsp_hold, next_rsp_hold;

    qsm_pin_sync #(.W(1)) u_req_sync (
        .clk_i(clk_link_i), .rst_i(link_rst_i), .d_i(req_tog), .q_o(req_q));
    qsm_pin_sync #(.W(1)) u_ack_sync (
        .clk_i(clk_sys_i), .rst_i(sys_rst_i), .d_i(ack_tog), .q_o(ack_q));

    // Request toggle, payload held
    always_comb begin
        next_req_tog = req_tog ^ start_i;
        next_req_hold = start_i ? req_i : req_hold;
        done_o = ack_q != ack_seen;
        rsp_o = rsp_hold;
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_tog <= 1'b0;
            ack_seen <= 1'b0;
            req_hold <= '0;
        end else begin
            req_tog <= next_req_tog;
            ack_seen <= ack_q;
            req_hold <= next_req_hold;
        end
    end

    // Start pulse, answer toggle
    always_comb begin
        bus.start = req_q != req_seen;
        bus.req = req_hold;
        next_ack_tog = ack_tog ^ bus.done;
        next_rsp_hold = bus.done ? bus.resp : rsp_hold;
    end
    always_ff @(posedge clk_link_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            req_seen <= 1'b0;
            ack_tog <= 1'b0;
            rsp_hold <= '0;
        end else begin
            req_seen <= req_q;
            ack_tog <= next_ack_tog;
            rsp_hold <= next_rsp_hold;
        end
    end
endmodule // qsm_hs_cdc

/* quad_serial_memory_master.sv */
`timescale 1ns/1ps
`include "qsm_consts.svh"
// Behaviour
// - Always master; drives the serial clock, up to 32 MHz.
// - Active low select, asserted only during a transaction.
// - Single lane: lane zero out, lane one in.
// - Dual and quad turn lanes around; lanes two, three in quad only.
// - Reads and writes on one, two or four lanes.
// - Serial clock rate between 2 and 32 MHz.
// - Quad mode moves four bits per serial clock in the data phases; opcode and address go one bit per clock.
// - Flash addresses are 32 bits.
// - Fetches map through a 128 MB window at a programmable base.
// - Commands enter and leave flash deep power-down.
// - Custom opcode, up to eight data bytes, response read.
// - Instruction data moves by direct memory access.
module quad_serial_memory_master #(
    parameter int LINK_KHZ = 166667
) (
    // Clocks and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_link_i,
    // Clock divider
    input wire logic [7:0] sck_half_i,
    // Custom instruction
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] cmd_opcode_i,
    input wire logic cmd_addr_en_i,
    input wire logic [`QSM_ADDR_BITS-1:0] cmd_addr_i,
    input wire logic [1:0] cmd_mode_i,
    input wire logic [3:0] cmd_wbytes_i,
    input wire logic [3:0] cmd_rbytes_i,
    input wire logic [`QSM_DATA_BITS-1:0] cmd_wdata_i,
    input wire logic cmd_dma_i,
    input wire logic [31:0] cmd_mem_addr_i,
    output logic cmd_done_o,
    output logic [`QSM_DATA_BITS-1:0] cmd_rdata_o,
    // Deep power-down control
    input wire logic pwr_valid_i,
    input wire logic pwr_down_i,
    output logic pwr_ready_o,
    output logic pwr_done_o,
    output logic dpd_o,
    // Execute in place fetch
    input wire logic xip_valid_i,
    output logic xip_ready_o,
    input wire logic [`QSM_ADDR_BITS-1:0] xip_base_i,
    input wire logic [`QSM_WIN_BITS-1:0] xip_offset_i,
    output logic xip_done_o,
    output logic [31:0] xip_data_o,
    // System memory access
    output logic dma_req_o,
    output logic dma_we_o,
    output logic [31:0] dma_addr_o,
    output logic [31:0] dma_wdata_o,
    input wire logic dma_ack_i,
    input wire logic [31:0] dma_rdata_i,
    // Flash pins
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] data_lane_o,
    output logic [3:0] data_lane_oe_o,
    input wire logic [3:0] data_lane_i
);
    localparam int HALF_MIN_I = (LINK_KHZ + 2 * `QSM_SCK_MAX_KHZ - 1) / (2 * `QSM_SCK_MAX_KHZ);
    localparam int HALF_MAX_I = LINK_KHZ / (2 * `QSM_SCK_MIN_KHZ);
    localparam logic [7:0] HALF_MIN = 8'(HALF_MIN_I);
    localparam logic [7:0] HALF_MAX = 8'(HALF_MAX_I);

    qsm_pkg::ctl_state_e st, next_st;
    qsm_pkg::op_kind_e kind, next_kind;
    qsm_pkg::xfer_s req, next_req;
    logic go, next_go;
    logic use_dma, next_use_dma;
    logic pwr_dn, next_pwr_dn;
    logic dpd, next_dpd;
    logic wcnt, next_wcnt;
    logic [31:0] maddr, next_maddr;
    logic [31:0] dwdata, next_dwdata;
    logic [`QSM_DATA_BITS-1:0] rdata, next_rdata;
    logic [7:0] half_c;
    logic [3:0] wb_c, rb_c;
    logic cdc_done;
    logic [`QSM_DATA_BITS-1:0] cdc_rsp;

    qsm_pkg::link_state_e lst, next_lst;
    logic sck, next_sck, cs_n, next_cs_n;
    logic [7:0] hc, next_hc;
    logic [6:0] cnt, next_cnt;
    logic [`QSM_DATA_BITS-1:0] sh, next_sh, rx, next_rx;
    logic [3:0] dout, next_dout, doe, next_doe;
    logic [3:0] lane_s;
    logic [2:0] lanes, lc;
    logic tick, last, act, wr;
    logic [1:0] lrst;
    logic link_rst;

    qsm_xfer_if xb ();

    qsm_hs_cdc u_cdc (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .start_i(go),
        .req_i(req),
        .done_o(cdc_done),
        .rsp_o(cdc_rsp),
        .clk_link_i(clk_link_i),
        .link_rst_i(link_rst),
        .bus(xb)
    );

    qsm_pin_sync #(.W(4)) u_lane_sync (
        .clk_i(clk_link_i),
        .rst_i(link_rst),
        .d_i(data_lane_i),
        .q_o(lane_s)
    );

    // Handshakes and outputs
    always_comb begin
        half_c = sck_half_i;
        if (sck_half_i < HALF_MIN) begin
            half_c = HALF_MIN;
        end else if (sck_half_i > HALF_MAX) begin
            half_c = HALF_MAX;
        end
        wb_c = (cmd_wbytes_i > `QSM_MAX_BYTES) ? `QSM_MAX_BYTES : cmd_wbytes_i;
        rb_c = (cmd_rbytes_i > `QSM_MAX_BYTES) ? `QSM_MAX_BYTES : cmd_rbytes_i;
        xip_ready_o = st == qsm_pkg::CS_IDLE;
        pwr_ready_o = xip_ready_o & ~xip_valid_i;
        cmd_ready_o = pwr_ready_o & ~pwr_valid_i;
        dma_req_o = (st == qsm_pkg::CS_FETCH) | (st == qsm_pkg::CS_STORE);
        dma_we_o = st == qsm_pkg::CS_STORE;
        cmd_done_o = (st == qsm_pkg::CS_DONE) && (kind == qsm_pkg::K_CMD);
        xip_done_o = (st == qsm_pkg::CS_DONE) && (kind == qsm_pkg::K_XIP);
        pwr_done_o = (st == qsm_pkg::CS_DONE) && (kind == qsm_pkg::K_PWR);
        dma_addr_o = maddr;
        dma_wdata_o = dwdata;
        cmd_rdata_o = rdata;
        xip_data_o = rdata[63:32];
        dpd_o = dpd;
    end

    // System side sequencer
    always_comb begin
        next_st = st;
        next_kind = kind;
        next_req = req;
        next_go = 1'b0;
        next_use_dma = use_dma;
        next_pwr_dn = pwr_dn;
        next_dpd = dpd;
        next_wcnt = wcnt;
        next_maddr = maddr;
        next_dwdata = dwdata;
        next_rdata = rdata;
        unique case (st)
            qsm_pkg::CS_IDLE: begin
                next_wcnt = 1'b0;
                if (xip_valid_i) begin
                    next_kind = qsm_pkg::K_XIP;
                    next_use_dma = 1'b0;
                    next_req = '{`QSM_OP_XIP, 1'b1,
                        xip_base_i + {5'h00, xip_offset_i},
                        qsm_pkg::LANE_FOUR, 4'h0,
                        `QSM_XIP_BYTES, 64'h0, half_c};
                    next_go = 1'b1;
                    next_st = qsm_pkg::CS_RUN;
                end else if (pwr_valid_i) begin
                    next_kind = qsm_pkg::K_PWR;
                    next_use_dma = 1'b0;
                    next_pwr_dn = pwr_down_i;
                    next_req = '{pwr_down_i ? `QSM_OP_DPD : `QSM_OP_WAKE,
                        1'b0, 32'h0, qsm_pkg::LANE_ONE,
                        4'h0, 4'h0, 64'h0, half_c};
                    next_go = 1'b1;
                    next_st = qsm_pkg::CS_RUN;
                end else if (cmd_valid_i) begin
                    next_kind = qsm_pkg::K_CMD;
                    next_use_dma = cmd_dma_i;
                    next_maddr = cmd_mem_addr_i;
                    next_req = '{cmd_opcode_i, cmd_addr_en_i,
                        cmd_addr_i, qsm_pkg::lane_mode_e'(cmd_mode_i),
                        wb_c, rb_c, cmd_wdata_i, half_c};
                    if (cmd_dma_i && wb_c != 4'h0) begin
                        next_st = qsm_pkg::CS_FETCH;
                    end else begin
                        next_go = 1'b1;
                        next_st = qsm_pkg::CS_RUN;
                    end
                end
            end
            qsm_pkg::CS_FETCH: begin
                if (dma_ack_i) begin
                    if (!wcnt) begin
                        next_req.wdata[63:32] = dma_rdata_i;
                    end else begin
                        next_req.wdata[31:0] = dma_rdata_i;
                    end
                    next_maddr = maddr + 32'h4;
                    next_wcnt = 1'b1;
                    if (wcnt || req.wbytes <= `QSM_WORD_BYTES) begin
                        next_wcnt = 1'b0;
                        next_go = 1'b1;
                        next_st = qsm_pkg::CS_RUN;
                    end
                end
            end
            qsm_pkg::CS_RUN: begin
                if (cdc_done) begin
                    next_rdata = cdc_rsp;
                    next_dwdata = cdc_rsp[63:32];
                    if (kind == qsm_pkg::K_CMD && use_dma && req.rbytes != 4'h0) begin
                        next_st = qsm_pkg::CS_STORE;
                    end else begin
                        next_st = qsm_pkg::CS_DONE;
                    end
                end
            end
            qsm_pkg::CS_STORE: begin
                if (dma_ack_i) begin
                    next_maddr = maddr + 32'h4;
                    next_dwdata = rdata[31:0];
                    next_wcnt = 1'b1;
                    if (wcnt || req.rbytes <= `QSM_WORD_BYTES) begin
                        next_wcnt = 1'b0;
                        next_st = qsm_pkg::CS_DONE;
                    end
                end
            end
            qsm_pkg::CS_DONE: begin
                if (kind == qsm_pkg::K_PWR) begin
                    next_dpd = pwr_dn;
                end
                next_st = qsm_pkg::CS_IDLE;
            end
            default: next_st = qsm_pkg::CS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= qsm_pkg::CS_IDLE;
            kind <= qsm_pkg::K_CMD;
            req <= '0;
            go <= 1'b0;
            use_dma <= 1'b0;
            pwr_dn <= 1'b0;
            dpd <= 1'b0;
            wcnt <= 1'b0;
            maddr <= 32'h0;
            dwdata <= 32'h0;
            rdata <= '0;
        end else begin
            st <= next_st;
            kind <= next_kind;
            req <= next_req;
            go <= next_go;
            use_dma <= next_use_dma;
            pwr_dn <= next_pwr_dn;
            dpd <= next_dpd;
            wcnt <= next_wcnt;
            maddr <= next_maddr;
            dwdata <= next_dwdata;
            rdata <= next_rdata;
        end
    end

    // Link reset, released on the link clock
    always_ff @(posedge clk_link_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lrst <= 2'h3;
        end else begin
            lrst <= {lrst[0], 1'b0};
        end
    end
    assign link_rst = lrst[1];

    // Link side serial engine
    always_comb begin
        next_lst = lst;
        next_sck = sck;
        next_cs_n = cs_n;
        next_cnt = cnt;
        next_sh = sh;
        next_rx = rx;
        tick = hc == (xb.req.half - 8'h01);
        next_hc = tick ? 8'h00 : hc + 8'h01;
        lc = qsm_pkg::lane_count(xb.req.mode);
        lanes = (lst == qsm_pkg::L_WR || lst == qsm_pkg::L_RD) ? lc : 3'h1;
        last = cnt == {4'h0, lanes};
        unique case (lst)
            qsm_pkg::L_IDLE: begin
                next_hc = 8'h00;
                next_sck = 1'b0;
                next_cs_n = 1'b1;
                if (xb.start) begin
                    next_cs_n = 1'b0;
                    next_lst = qsm_pkg::L_SEL;
                end
            end
            qsm_pkg::L_SEL: begin
                if (tick) begin
                    next_sh = {xb.req.opcode, 56'h0};
                    next_cnt = `QSM_OP_CNT;
                    next_lst = qsm_pkg::L_OP;
                end
            end
            qsm_pkg::L_OP, qsm_pkg::L_ADDR, qsm_pkg::L_WR, qsm_pkg::L_RD: begin
                if (tick && !sck) begin
                    next_sck = 1'b1;
                    if (lst == qsm_pkg::L_RD) begin
                        unique case (lc)
                            3'h4: next_rx = {rx[59:0], lane_s};
                            3'h2: next_rx = {rx[61:0], lane_s[1:0]};
                            default: next_rx = {rx[62:0], lane_s[1]};
                        endcase
                    end
                end else if (tick) begin
                    next_sck = 1'b0;
                    next_sh = sh << lanes;
                    next_cnt = cnt - {4'h0, lanes};
                    if (!last) begin
                        next_lst = lst;
                    end else if (lst == qsm_pkg::L_OP && xb.req.addr_en) begin
                        next_sh = {xb.req.addr, 32'h0};
                        next_cnt = `QSM_ADDR_CNT;
                        next_lst = qsm_pkg::L_ADDR;
                    end else if (lst != qsm_pkg::L_WR && lst != qsm_pkg::L_RD
                            && xb.req.wbytes != 4'h0) begin
                        next_sh = xb.req.wdata;
                        next_cnt = {xb.req.wbytes, 3'h0};
                        next_lst = qsm_pkg::L_WR;
                    end else if (lst != qsm_pkg::L_RD && xb.req.rbytes != 4'h0) begin
                        next_rx = '0;
                        next_cnt = {xb.req.rbytes, 3'h0};
                        next_lst = qsm_pkg::L_RD;
                    end else begin
                        next_lst = qsm_pkg::L_HOLD;
                    end
                end
            end
            qsm_pkg::L_HOLD: begin
                if (tick) begin
                    next_cs_n = 1'b1;
                    next_rx = rx << (7'h40 - {xb.req.rbytes, 3'h0});
                    next_lst = qsm_pkg::L_END;
                end
            end
            qsm_pkg::L_END: next_lst = qsm_pkg::L_IDLE;
        endcase
        xb.done = lst == qsm_pkg::L_END;
        xb.resp = rx;
        // Lane drive for next state
        act = next_lst != qsm_pkg::L_IDLE && next_lst != qsm_pkg::L_END;
        wr = next_lst == qsm_pkg::L_WR;
        next_dout = {3'h0, next_sh[63]};
        if (wr && lc == 3'h4) begin
            next_dout = next_sh[63:60];
        end else if (wr && lc == 3'h2) begin
            next_dout = {2'h0, next_sh[63:62]};
        end
        next_doe[0] = act && !(next_lst == qsm_pkg::L_RD && lc != 3'h1);
        next_doe[1] = wr && lc != 3'h1;
        next_doe[2] = wr && lc == 3'h4;
        next_doe[3] = wr && lc == 3'h4;
    end

    always_ff @(posedge clk_link_i or posedge link_rst) begin
        if (link_rst) begin
            lst <= qsm_pkg::L_IDLE;
            sck <= 1'b0;
            cs_n <= 1'b1;
            hc <= 8'h00;
            cnt <= 7'h00;
            sh <= '0;
            rx <= '0;
            dout <= 4'h0;
            doe <= 4'h0;
        end else begin
            lst <= next_lst;
            sck <= next_sck;
            cs_n <= next_cs_n;
            hc <= next_hc;
            cnt <= next_cnt;
            sh <= next_sh;
            rx <= next_rx;
            dout <= next_dout;
            doe <= next_doe;
        end
    end

    assign sck_o = sck;
    assign cs_n_o = cs_n;
    assign data_lane_o = dout;
    assign data_lane_oe_o = doe;
endmodule // quad_serial_memory_master

/* qsm_monitor.sv */
`timescale 1ns/1ps
module qsm_monitor (
    // Clocks and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_link_i,
    // Requests
    input wire logic [7:0] sck_half_i,
    input wire logic xip_valid_i,
    input wire logic cmd_ready_o,
    input wire logic pwr_ready_o,
    input wire logic cmd_done_o,
    input wire logic pwr_done_o,
    input wire logic xip_done_o,
    // Memory access
    input wire logic dma_req_o,
    input wire logic dma_ack_i,
    input wire logic [31:0] dma_addr_o,
    // Flash pins
    input wire logic sck_o,
    input wire logic cs_n_o,
    input wire logic [3:0] data_lane_oe_o
);
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    logic any_done;
    assign any_done = cmd_done_o | pwr_done_o | xip_done_o;
    always_comb next_hi_cnt = sck_o ? hi_cnt + 8'h01 : 8'h00;
    always_ff @(posedge clk_link_i or posedge sys_rst_i) begin
        if (sys_rst_i) hi_cnt <= 8'h00;
        else hi_cnt <= next_hi_cnt;
    end
    sel_idle_a: assert property (@(posedge clk_link_i) disable iff (sys_rst_i)
        cs_n_o |-> !sck_o) else $error("clock while idle");
    cs_lead_a: assert property (@(posedge clk_link_i) disable iff (sys_rst_i)
        $fell(cs_n_o) |-> !sck_o [*3]) else $error("early clock");
    sck_high_a: assert property (@(posedge clk_link_i) disable iff (sys_rst_i)
        $fell(sck_o) |-> hi_cnt == sck_half_i) else $error("bad half period");
    quad_pair_a: assert property (@(posedge clk_link_i) disable iff (sys_rst_i)
        data_lane_oe_o[3] == data_lane_oe_o[2]) else $error("upper lanes split");
    quad_drv_a: assert property (@(posedge clk_link_i) disable iff (sys_rst_i)
        data_lane_oe_o[2] |-> data_lane_oe_o[1:0] == 2'h3) else $error("quad lanes off");
    done_pulse_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        any_done |=> !any_done) else $error("long done");
    xip_first_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        xip_valid_i |-> !cmd_ready_o && !pwr_ready_o) else $error("fetch priority");
    dma_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_addr_o))
        else $error("dma moved");
endmodule // qsm_monitor
bind quad_serial_memory_master qsm_monitor qsm_monitor_i (.*);

/* qsm_flash_model.sv */
`timescale 1ns/1ps
module qsm_flash_model (
    // Flash pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] pin_d_i,
    input wire logic [3:0] pin_oe_i,
    output logic [3:0] pin_q_o,
    // Frame layout
    input wire logic [5:0] hdr_len_i,
    input wire logic [7:0] skip_i,
    input wire logic [2:0] lanes_i,
    input wire logic [63:0] rsp_i,
    // Captured traffic
    output logic [39:0] hdr_o,
    output logic [63:0] dat_o
);
    logic [7:0] cnt;
    logic [63:0] sh;
    logic [3:0] drv = 4'h5;
    logic [3:0] msk;
    assign msk = 4'((5'h01 << lanes_i) - 5'h01);
    assign pin_q_o = (pin_oe_i & pin_d_i) | (~pin_oe_i & drv);
    always @(negedge cs_n_i) begin
        cnt = 8'h00;
        hdr_o = 40'h0;
        dat_o = 64'h0;
        sh = rsp_i;
    end
    always @(posedge cs_n_i) drv = ~drv;
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            if (cnt < 8'(hdr_len_i)) hdr_o = {hdr_o[38:0], pin_d_i[0]};
            else if (cnt < skip_i) dat_o = (dat_o << lanes_i) | 64'(pin_d_i & msk);
            cnt = cnt + 8'h01;
        end
    end
    always @(negedge sck_i) begin
        if (!cs_n_i && cnt >= skip_i) begin
            case (lanes_i)
                3'h1: drv = {~drv[3:2], sh[63], ~drv[0]};
                3'h2: drv = {~drv[3:2], sh[63:62]};
                default: drv = sh[63:60];
            endcase
            sh = sh << lanes_i;
        end else begin
            drv = ~drv;
        end
    end
endmodule // qsm_flash_model

/* testbench.sv */
`timescale 1ns/1ps
`include "qsm_consts.svh"
module testbench;
    logic clk_sys_i, sys_rst_i, clk_link_i, cmd_valid_i, pwr_valid_i, xip_valid_i;
    logic cmd_addr_en_i, cmd_dma_i, pwr_down_i, dma_ack_i, ae;
    logic cmd_ready_o, cmd_done_o, pwr_ready_o, pwr_done_o, dpd_o, xip_ready_o, xip_done_o;
    logic dma_req_o, dma_we_o, sck_o, cs_n_o;
    logic [7:0] sck_half_i, cmd_opcode_i, skip;
    logic [1:0] cmd_mode_i;
    logic [3:0] cmd_wbytes_i, cmd_rbytes_i, data_lane_o, data_lane_oe_o, data_lane_i;
    logic [31:0] cmd_addr_i, cmd_mem_addr_i, xip_base_i, dma_rdata_i, xip_data_o, dma_addr_o;
    logic [31:0] dma_wdata_o;
    logic [31:0] stored [2];
    logic [26:0] xip_offset_i;
    logic [63:0] cmd_wdata_i, cmd_rdata_o, rsp, dat;
    logic [39:0] hdr;
    logic [5:0] hdr_len;
    logic [2:0] lanes;
    int n_mismatch, num_checks, j, wb, rb;
    quad_serial_memory_master quad_serial_memory_master_i (.*);
    qsm_flash_model qsm_flash_model_i (.sck_i(sck_o), .cs_n_i(cs_n_o), .pin_d_i(data_lane_o),
        .pin_oe_i(data_lane_oe_o), .pin_q_o(data_lane_i), .hdr_len_i(hdr_len), .skip_i(skip),
        .lanes_i(lanes), .rsp_i(rsp), .hdr_o(hdr), .dat_o(dat));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        clk_link_i = 1'b0;
        #1.3;
        forever #3 clk_link_i = ~clk_link_i;
    end
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    always @(posedge clk_sys_i) begin
        dma_ack_i <= dma_req_o && !dma_ack_i && ($urandom % 3 == 0);
        dma_rdata_i <= mem_word(dma_addr_o);
        if (dma_ack_i && dma_we_o) stored[dma_addr_o[2]] <= dma_wdata_o;
    end
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic go(input int k);
        int n;
        {cmd_valid_i, pwr_valid_i, xip_valid_i} <= 3'h1 << k;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys_i);
            if (|({cmd_ready_o, pwr_ready_o, xip_ready_o} & (3'h1 << k))) break;
        end
        if (n == 50) n_mismatch++;
        @(posedge clk_sys_i);
        {cmd_valid_i, pwr_valid_i, xip_valid_i} <= 3'h0;
        for (n = 0; n < 8000; n++) begin
            @(negedge clk_sys_i);
            if (|({cmd_done_o, pwr_done_o, xip_done_o} & (3'h1 << k))) break;
        end
        if (n == 8000) begin
            n_mismatch++;
            close_out();
        end
        repeat (2) @(negedge clk_sys_i);
    endtask
    initial begin
        {cmd_valid_i, pwr_valid_i, xip_valid_i} = '0;
        {cmd_opcode_i, cmd_addr_en_i, cmd_addr_i, cmd_mode_i, cmd_wbytes_i} = '0;
        {cmd_rbytes_i, cmd_wdata_i, cmd_dma_i, cmd_mem_addr_i, pwr_down_i} = '0;
        {xip_base_i, xip_offset_i, n_mismatch, num_checks} = '0;
        sys_rst_i = 1'b1;
        sck_half_i = 8'h08;
        {hdr_len, skip, lanes, rsp} = {6'h08, 8'h08, 3'h1, 64'h0};
        void'($urandom(30452));
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk("idle_pins", {cs_n_o, sck_o, data_lane_oe_o, dpd_o}, 64'h40);
        for (j = 0; j < 2; j++) begin
            @(posedge clk_sys_i);
            pwr_down_i <= (j == 0);
            go(1);
            chk("pwr_op", hdr, j == 0 ? `QSM_OP_DPD : `QSM_OP_WAKE);
            chk("dpd", dpd_o, j == 0);
        end
        $display("test power done");
        for (j = 0; j < 4; j++) begin
            @(posedge clk_sys_i);
            xip_base_i <= j == 0 ? 32'hFFFFFFF0 : $urandom;
            xip_offset_i <= j == 0 ? 27'h7FFFFFF : 27'($urandom);
            sck_half_i <= 8'(6 + $urandom % 15);
            {hdr_len, skip, lanes, rsp} = {6'h28, 8'h28, 3'h4, $urandom, $urandom};
            go(0);
            chk("xip_hdr", hdr, {`QSM_OP_XIP, xip_base_i + 32'(xip_offset_i)});
            chk("xip_data", xip_data_o, rsp[63:32]);
        end
        $display("test fetch done");
        for (j = 0; j < 10; j++) begin
            @(posedge clk_sys_i);
            wb = j < 2 ? 8 * j : j == 9 ? 8 : $urandom % 9;
            rb = j < 2 ? 8 - 8 * j : j == 9 ? 8 : $urandom % 9;
            ae = 1'($urandom);
            lanes = j % 4 == 1 ? 3'h2 : j % 4 == 2 ? 3'h4 : 3'h1;
            {cmd_mode_i, cmd_addr_en_i, cmd_dma_i} <= {2'(j), ae, j == 9};
            {cmd_opcode_i, cmd_addr_i} <= {8'($urandom), $urandom};
            {cmd_wbytes_i, cmd_rbytes_i} <= {4'(wb), 4'(rb)};
            cmd_wdata_i <= {$urandom, $urandom};
            cmd_mem_addr_i <= $urandom & 32'hFFFFFFF8;
            hdr_len = ae ? 6'h28 : 6'h08;
            skip = 8'(hdr_len) + 8'(8 * wb / lanes);
            rsp = {$urandom, $urandom};
            go(2);
            chk("cmd_hdr", hdr, ae ? {cmd_opcode_i, cmd_addr_i} : cmd_opcode_i);
            chk("cmd_wr", dat, j == 9 ? {mem_word(cmd_mem_addr_i),
                mem_word(cmd_mem_addr_i + 32'h4)} : cmd_wdata_i >> (64 - 8 * wb));
            if (j != 9) chk("cmd_rd", cmd_rdata_o >> (64 - 8 * rb), rsp >> (64 - 8 * rb));
            if (j == 9) chk("dma_store", {stored[0], stored[1]}, rsp);
        end
        $display("test custom done");
        close_out();
    end
endmodule // testbench
